// *** verilog/ppm_port_mux.v ***
// Purpose: port C pin multiplexer (24 pins) with per-pin input qualification
// Assumes: single 100 MHz core_clk, async active-low nrst, Avalon-MM slave
// Notes: lower 16 pins carry external data bits, upper 8 external address bits
`timescale 1ns/10ps
`include "ppm_port_regs.vh"

module ppm_port_mux
#(
  parameter NPIN_LO = 16,
  parameter NPIN_HI = 8,
  parameter [15:0] EXT_DATA_DFLT = 16'h0000
)
(
  core_clk,
  nrst,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_byteenable,
  avs_readdata,
  avs_waitrequest,
  pin_in,
  pin_out,
  pin_oe,
  gpio_out,
  gpio_dir,
  gpio_in,
  ext_data_out,
  ext_data_oe,
  ext_data_in,
  ext_addr_bit,
  alt_data_in,
  alt_data_sel
);
  input wire core_clk;
  input wire nrst;
  input wire [4:0] avs_address;
  input wire avs_read;
  input wire avs_write;
  input wire [31:0] avs_writedata;
  input wire [3:0] avs_byteenable;
  output reg [31:0] avs_readdata;
  output reg avs_waitrequest;
  input wire [23:0] pin_in;
  output reg [23:0] pin_out;
  output reg [23:0] pin_oe;
  input wire [23:0] gpio_out;
  input wire [23:0] gpio_dir;
  output reg [23:0] gpio_in;
  input wire [15:0] ext_data_out;
  input wire [15:0] ext_data_oe;
  output reg [15:0] ext_data_in;
  input wire [15:8] ext_addr_bit;
  input wire [15:0] alt_data_in;
  input wire [15:0] alt_data_sel;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // upper bit of a two-bit field picks the external function;
  // the low bit is ignored, so 00/01 and 10/11 behave alike
  function field_hi;
    input [31:0] word;
    input integer idx;
    begin
      field_hi = word[2 * idx + 1];
    end
  endfunction

  // two-bit field of a packed select word
  function [1:0] field2;
    input [31:0] word;
    input integer idx;
    begin
      field2 = word[2 * idx +: 2];
    end
  endfunction

  // byte-lane merge for register writes
  function [31:0] be_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] be;
    integer b;
    begin
      be_merge = old_val;
      for (b = 0; b < 4; b = b + 1)
        if (be[b])
          be_merge[8 * b +: 8] = new_val[8 * b +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register storage
  reg [31:0] port_c_mux_low_r;   // fields for pins 0..15
  reg [15:0] port_c_mux_high_r;  // fields for pins 16..23
  reg [31:0] qsel_low_r;         // input_qual_select, pins 0..15
  reg [15:0] qsel_high_r;        // input_qual_select, pins 16..23
  reg [23:0] port_control_r;     // qual_sample_period, byte per group
  reg [31:0] rd_nxt;             // read mux result
  reg [31:0] wr_word;            // merged write value
  wire acc_go;                   // request sampled this edge
  wire wr_now;                   // write takes effect this edge
  reg [31:0] mux_high_w;         // widened views for field helpers
  reg [31:0] qsel_high_w;

  // waitrequest idles high, so every access costs exactly one wait
  // cycle; that halves the bus rate but keeps read data registered
  // and lets a write land only once the master has seen the answer
  // request is seen while waitrequest is still high
  assign acc_go = (avs_read | avs_write) & avs_waitrequest;
  // write lands on the edge where waitrequest is low
  assign wr_now = avs_write & ~avs_waitrequest;

  always @*
  begin
    mux_high_w = {16'h0000, port_c_mux_high_r};
    qsel_high_w = {16'h0000, qsel_high_r};
  end

  ////////////////////////////////////////////////////////////////////////
  // read decode; unmapped offsets read zero
  // there is no error response, so a stray address simply reads zero
  // and a stray write is dropped
  always @*
  begin
    rd_nxt = 32'h00000000;
    case (avs_address)
      `PPM_OFS_MUX_LOW: rd_nxt = port_c_mux_low_r;
      `PPM_OFS_MUX_HIGH: rd_nxt = mux_high_w;
      `PPM_OFS_QSEL_LOW: rd_nxt = qsel_low_r;
      `PPM_OFS_QSEL_HIGH: rd_nxt = qsel_high_w;
      `PPM_OFS_PORT_CTRL: rd_nxt = {8'h00, port_control_r};
      // live qualified pin levels as the core sees them
      `PPM_OFS_PIN_STATE: rd_nxt = {8'h00, gpio_in};
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // current value of the addressed register, for byte merging
  always @*
  begin
    wr_word = be_merge(rd_nxt, avs_writedata, avs_byteenable);
  end

  ////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle per access, then release
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end
    else if (acc_go)
    begin
      // answer on the next edge
      avs_waitrequest <= 1'b0;
      if (avs_read)
        avs_readdata <= rd_nxt;
    end
    else
    begin
      // back to stalling so every access gets a fresh answer
      avs_waitrequest <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register writes
  // a master that drops its request before the answer loses the write;
  // nothing is latched at the accepting edge
  // all zero at reset
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      port_c_mux_low_r <= `PPM_RST_MUX_LOW;
      port_c_mux_high_r <= `PPM_RST_MUX_HIGH;
      qsel_low_r <= `PPM_RST_QSEL_LOW;
      qsel_high_r <= `PPM_RST_QSEL_HIGH;
      port_control_r <= `PPM_RST_PORT_CTRL;
    end
    else if (wr_now)
    begin
      case (avs_address)
        `PPM_OFS_MUX_LOW: port_c_mux_low_r <= wr_word;
        `PPM_OFS_MUX_HIGH: port_c_mux_high_r <= wr_word[15:0];
        `PPM_OFS_QSEL_LOW: qsel_low_r <= wr_word;
        `PPM_OFS_QSEL_HIGH: qsel_high_r <= wr_word[15:0];
        `PPM_OFS_PORT_CTRL: port_control_r <= wr_word[23:0];
        // status and unmapped offsets ignore writes
        default: port_c_mux_low_r <= port_c_mux_low_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sample period dividers, one per group of eight pins
  // the counters free-run and are not aligned to pin edges, so a
  // qualified change may land up to one period later than the minimum
  // the compare is >= so that a shorter period written while a count is
  // running restarts the group at once instead of wrapping through 255
  // shared period per group
  reg [`PPM_PRD_W-1:0] prd_cnt_r [0:2];  // cycles since last sample
  reg [2:0] sample_en_r;                 // one-cycle sample pulses
  integer g;

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (g = 0; g < 3; g = g + 1)
        prd_cnt_r[g] <= {`PPM_PRD_W{1'b0}};
      sample_en_r <= 3'h0;
    end
    else
    begin
      for (g = 0; g < 3; g = g + 1)
      begin
        // period 0 or 1 samples every clock
        if (prd_cnt_r[g] + 8'h01 >= port_control_r[8 * g +: 8])
        begin
          prd_cnt_r[g] <= {`PPM_PRD_W{1'b0}};
          sample_en_r[g] <= 1'b1;
        end
        else
        begin
          prd_cnt_r[g] <= prd_cnt_r[g] + 8'h01;
          sample_en_r[g] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-pin qualifiers
  // each pin keeps its own synchroniser and window; only the sample
  // pulse is shared by the eight pins of a group
  wire [23:0] qual_w;     // qualified pin levels
  reg [47:0] qsel_all;    // two select bits per pin

  always @*
  begin
    qsel_all = {qsel_high_r, qsel_low_r};
  end

  genvar p;
  generate
    for (p = 0; p < 24; p = p + 1)
    begin : g_qual
      ppm_qual u_qual
      (
        .core_clk(core_clk),
        .nrst(nrst),
        .pin_raw(pin_in[p]),
        .qsel(qsel_all[2 * p +: 2]),
        .sample_en(sample_en_r[p / `PPM_GROUP_PINS]),
        .qual_out(qual_w[p])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // output mux; next values
  // address pins are output-only: their level still reaches the core
  // through gpio_in but never the external bus
  // a data pin routed to the bus also keeps reporting on gpio_in, which
  // leaves software a way to watch a stuck bus line
  reg [23:0] pin_out_nxt;
  reg [23:0] pin_oe_nxt;
  reg [15:0] ext_in_nxt;
  integer n;

  always @*
  begin
    pin_out_nxt = gpio_out;
    pin_oe_nxt = gpio_dir;
    ext_in_nxt = EXT_DATA_DFLT;
    for (n = 0; n < NPIN_LO; n = n + 1)
    begin
      // pin n carries data bit 15-n
      if (field_hi(port_c_mux_low_r, n))
      begin
        pin_out_nxt[n] = ext_data_out[15 - n];
        pin_oe_nxt[n] = ext_data_oe[15 - n];
        ext_in_nxt[15 - n] = qual_w[n];
      end
      // another port may feed the same bit
      else if (alt_data_sel[15 - n])
        ext_in_nxt[15 - n] = alt_data_in[15 - n];
      else
        ext_in_nxt[15 - n] = EXT_DATA_DFLT[15 - n];
    end
    for (n = 0; n < NPIN_HI; n = n + 1)
    begin
      if (field_hi(mux_high_w, n))
      begin
        pin_out_nxt[NPIN_LO + n] = ext_addr_bit[8 + n];
        pin_oe_nxt[NPIN_LO + n] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs; costs one cycle but keeps pins glitch-free
  // at reset every pin is released (output enable low) and the bus
  // side sees zero until the first clock after release; the pads
  // then follow the mux one cycle behind any register write
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_out <= 24'h000000;
      pin_oe <= 24'h000000;
      gpio_in <= 24'h000000;
      ext_data_in <= 16'h0000;
    end
    else
    begin
      pin_out <= pin_out_nxt;
      pin_oe <= pin_oe_nxt;
      gpio_in <= qual_w;
      ext_data_in <= ext_in_nxt;
    end
  end
endmodule

// *** verilog/ppm_port_regs.vh ***
// Purpose: constants for the port C pin multiplexer and input qualifier
// Assumes: 32-bit Avalon-MM register words on byte addresses
// Notes: included by the top module and the qualifier
`ifndef PPM_PORT_REGS_VH
`define PPM_PORT_REGS_VH

// register byte offsets
`define PPM_OFS_MUX_LOW 5'h00
`define PPM_OFS_MUX_HIGH 5'h04
`define PPM_OFS_QSEL_LOW 5'h08
`define PPM_OFS_QSEL_HIGH 5'h0C
`define PPM_OFS_PORT_CTRL 5'h10
`define PPM_OFS_PIN_STATE 5'h14

// reset values: all pins start as general-purpose, sync only
`define PPM_RST_MUX_LOW 32'h00000000
`define PPM_RST_MUX_HIGH 16'h0000
`define PPM_RST_QSEL_LOW 32'h00000000
`define PPM_RST_QSEL_HIGH 16'h0000
`define PPM_RST_PORT_CTRL 24'h000000

// qualification select codes
`define PPM_QSEL_SYNC 2'h0
`define PPM_QSEL_WIN3 2'h1
`define PPM_QSEL_WIN6 2'h2
`define PPM_QSEL_ASYNC 2'h3

// sampling period field: one byte per group of pins
`define PPM_PRD_W 8
`define PPM_GROUP_PINS 8

// sampling window depths
`define PPM_WIN_SHORT 3
`define PPM_WIN_LONG 6

`endif

// *** verilog/ppm_qual.v ***
// Purpose: input qualifier for one port pin
// Assumes: pin_raw is asynchronous to core_clk; sample_en is a one-cycle pulse
// Notes: output level changes only as the selected mode allows
`timescale 1ns/10ps
`include "ppm_port_regs.vh"

module ppm_qual
(
  core_clk,
  nrst,
  pin_raw,
  qsel,
  sample_en,
  qual_out
);
  input wire core_clk;
  input wire nrst;
  input wire pin_raw;
  input wire [1:0] qsel;
  input wire sample_en;
  output wire qual_out;

  ////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser; only the second stage is read downstream
  reg meta_r;   // first stage, read by sync_r only
  reg sync_r;   // synchronised pin level
  reg [5:0] win_r;   // sampling window, newest sample in bit 0
  reg filt_r;   // last agreed window level
  reg filt_nxt;

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= pin_raw;
      sync_r <= meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // window agreement check
  always @*
  begin
    filt_nxt = filt_r;
    if (qsel == `PPM_QSEL_WIN3)
    begin
      if (win_r[2:0] == 3'h7)
        filt_nxt = 1'b1;
      else if (win_r[2:0] == 3'h0)
        filt_nxt = 1'b0;
    end
    else if (qsel == `PPM_QSEL_WIN6)
    begin
      if (win_r == 6'h3F)
        filt_nxt = 1'b1;
      else if (win_r == 6'h00)
        filt_nxt = 1'b0;
    end
  end

  // shift samples on the period pulse
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      win_r <= 6'h00;
      filt_r <= 1'b0;
    end
    else
    begin
      if (sample_en)
        win_r <= {win_r[4:0], sync_r};
      filt_r <= filt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode select; the caller registers the result
  // qsel 3 passes pin_raw, 0 gives sync_r, 1 and 2 give filt_r
  assign qual_out = (qsel == `PPM_QSEL_ASYNC) ? pin_raw :
                    (qsel == `PPM_QSEL_SYNC) ? sync_r : filt_r;
endmodule

// *** tb/ppm_pin_model.sv ***
// Purpose: far-side pads and pin drivers
// Assumes: pad_lvl is what an outside driver puts on a pin
// Notes: a pin the device drives reads back its own level
`timescale 1ns/10ps
module ppm_pin_model
(
  input wire [23:0] pin_out,
  input wire [23:0] pin_oe,
  input wire [23:0] pad_lvl,
  output wire [23:0] pin_in
);
  // the device wins where it drives, the pad elsewhere
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & pad_lvl);
endmodule

// *** tb/ppm_port_mux_chk.sv ***
// Purpose: routing and qualifier checks at the ports
// Assumes: full-word register writes
// Notes: pin 0 and pin 16 stand for their halves
`timescale 1ns/10ps
module ppm_port_mux_chk
#(
  parameter [15:0] EXT_DATA_DFLT = 16'h0000
)
(
  input wire core_clk,
  input wire nrst,
  input wire [4:0] avs_address,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire avs_waitrequest,
  input wire [23:0] pin_in,
  input wire [23:0] pin_out,
  input wire [23:0] pin_oe,
  input wire [23:0] gpio_out,
  input wire [23:0] gpio_dir,
  input wire [23:0] gpio_in,
  input wire [15:0] ext_data_out,
  input wire [15:0] ext_data_oe,
  input wire [15:0] ext_data_in,
  input wire [15:8] ext_addr_bit,
  input wire [15:0] alt_data_in,
  input wire [15:0] alt_data_sel
);
  default clocking dc @(posedge core_clk);
  endclocking
  // low through the release edge; an attempt started there would
  // hold reset-time outputs against live inputs
  reg up_r;
  default disable iff (!nrst || !up_r);
  // write lands where waitrequest is sampled low
  wire wt = avs_write && !avs_waitrequest;
  reg [31:0] mlo_r, mhi_r, qlo_r;
  // low run of pin 0; long enough to flush any window
  reg [10:0] lc_r;
  ////////////////////////////////////////////////////////////
  // shadows, so routing can be judged from the ports alone
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mlo_r <= 32'h00000000;
      mhi_r <= 32'h00000000;
      qlo_r <= 32'h00000000;
      lc_r <= 11'h000;
      up_r <= 1'b0;
    end
    else
    begin
      up_r <= 1'b1;
      if (wt && avs_address == 5'h00)
        mlo_r <= avs_writedata;
      if (wt && avs_address == 5'h04)
        mhi_r <= avs_writedata;
      if (wt && avs_address == 5'h08)
        qlo_r <= avs_writedata;
      lc_r <= pin_in[0] ? 11'h000 : lc_r + {10'h000, ~&lc_r};
    end
  end
  ////////////////////////////////////////////////////////////
  chk_data_route:
  assert property (mlo_r[1] |=> pin_oe[0] == $past(ext_data_oe[15]) && pin_out[0] == $past(ext_data_out[15]))
    else $error("data pin route wrong");
  chk_gpio_route:
  assert property (!mlo_r[1] |=> pin_oe[0] == $past(gpio_dir[0]) && pin_out[0] == $past(gpio_out[0]))
    else $error("gpio pin route wrong");
  chk_addr_route:
  assert property (mhi_r[1] |=> pin_oe[16] && pin_out[16] == $past(ext_addr_bit[8]))
    else $error("address pin route wrong");
  chk_idle_level:
  assert property (!mlo_r[1] && !alt_data_sel[15] |=> ext_data_in[15] == EXT_DATA_DFLT[15])
    else $error("unrouted input not at default");
  chk_alt_source:
  assert property (!mlo_r[1] && alt_data_sel[15] |=> ext_data_in[15] == $past(alt_data_in[15]))
    else $error("alternate source not routed");
  chk_sync_lat:
  assert property (qlo_r[1:0] == 2'h0 && $past(qlo_r[1:0], 3) == 2'h0 && $past(nrst, 3)
    |-> gpio_in[0] == $past(pin_in[0], 3))
    else $error("sync path latency wrong");
  chk_raw_pass:
  assert property ($past(qlo_r[1:0]) == 2'h3 && $past(nrst) |-> gpio_in[0] == $past(pin_in[0]))
    else $error("raw path not direct");
  chk_glitch_held:
  assert property ((qlo_r[1] ^ qlo_r[0]) && !gpio_in[0] && lc_r == 11'h7FF && pin_in[0] ##1 !pin_in[0]
    |=> !gpio_in[0] [*6])
    else $error("glitch passed the window");
endmodule

// *** tb/ppm_port_mux_tb.sv ***
// Purpose: self-checking bench for the port mux
// Assumes: reads are checked from a queue of expectations
// Notes: sources toggle at random while routing is exercised
`timescale 1ns/10ps
module ppm_port_mux_tb;
  reg core_clk = 1'b0;
  reg nrst = 1'b0;
  reg [4:0] avs_address = 5'h00;
  reg avs_read = 1'b0, avs_write = 1'b0, rnd_on = 1'b0;
  reg [3:0] avs_byteenable = 4'hF;
  reg [31:0] avs_writedata = 32'h00000000, r;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire [23:0] pin_in, pin_out, pin_oe, gpio_in;
  wire [15:0] ext_data_in;
  reg [23:0] gpio_out = 24'h000000, gpio_dir = 24'h000000, pad_lvl = 24'h000000;
  reg [15:0] ext_data_out = 16'h0000, ext_data_oe = 16'h0000, alt_data_in = 16'h0000, alt_data_sel = 16'h0000;
  reg [15:8] ext_addr_bit = 8'h00;
  integer fails = 0, n_checks = 0, i, j;
  reg [31:0] exq [$];
  always #5 core_clk = ~core_clk;
  ppm_port_mux ppm_port_mux_i (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .gpio_out(gpio_out), .gpio_dir(gpio_dir), .gpio_in(gpio_in), .ext_data_out(ext_data_out),
    .ext_data_oe(ext_data_oe), .ext_data_in(ext_data_in), .ext_addr_bit(ext_addr_bit),
    .alt_data_in(alt_data_in), .alt_data_sel(alt_data_sel));
  ppm_pin_model ppm_pin_model_i (.pin_out(pin_out), .pin_oe(pin_oe), .pad_lvl(pad_lvl), .pin_in(pin_in));
  ////////////////////////////////////////////////////////////
  // random sources; pins stay undriven while pad tests run
  always @(posedge core_clk)
  begin
    gpio_out <= 24'($urandom);
    gpio_dir <= rnd_on ? 24'($urandom) : 24'h000000;
    ext_data_out <= 16'($urandom);
    ext_data_oe <= 16'($urandom);
    ext_addr_bit <= 8'($urandom);
    alt_data_in <= 16'($urandom);
    alt_data_sel <= 16'($urandom);
  end
  task results;
  begin
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  task chk(input [31:0] g, input [31:0] e);
  begin
    n_checks = n_checks + 1;
    if (g !== e)
    begin
      fails = fails + 1;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  end
  endtask
  // one Avalon access, held until waitrequest is sampled low
  task bus(input [4:0] a, input w, input [31:0] d);
    integer k;
  begin
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    k = 0;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0 && k < 20)
    begin
      k = k + 1;
      @(posedge core_clk);
    end
    if (avs_waitrequest !== 1'b0)
    begin
      fails = fails + 1;
      results;
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  end
  endtask
  task rd(input [4:0] a, input [31:0] e);
  begin
    exq.push_back(e);
    bus(a, 1'b0, 32'h00000000);
  end
  endtask
  // watcher: read data taken at the edge the answer comes
  always @(posedge core_clk)
    if (avs_read && avs_waitrequest === 1'b0 && exq.size() > 0)
      chk(avs_readdata, exq.pop_front());
  ////////////////////////////////////////////////////////////
  initial
  begin
    i = $urandom(32'h61C78C18);
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    for (i = 0; i < 5; i = i + 1)
      rd(5'(4 * i), 32'h00000000);
    $display("end reset values");
    rnd_on <= 1'b1;
    for (j = 0; j < 6; j = j + 1)
      for (i = 0; i < 5; i = i + 1)
      begin
        r = $urandom;
        pad_lvl <= r[31:8];
        bus(5'(4 * i), 1'b1, r);
        rd(5'(4 * i), r & ((i % 2) ? 32'h0000FFFF : (i == 4) ? 32'h00FFFFFF : 32'hFFFFFFFF));
        repeat (20) @(posedge core_clk);
      end
    bus(5'h18, 1'b1, r);
    rd(5'h18, 32'h00000000);
    $display("end routing");
    rnd_on <= 1'b0;
    for (i = 0; i < 5; i = i + 1)
      bus(5'(4 * i), 1'b1, 32'h00000000);
    r = $urandom;
    pad_lvl <= r[23:0];
    repeat (4) @(posedge core_clk);
    rd(5'h14, {8'h00, r[23:0]});
    bus(5'h08, 1'b1, 32'hFFFFFFFF);
    bus(5'h0C, 1'b1, 32'h0000FFFF);
    pad_lvl <= ~r[23:0];
    rd(5'h14, {8'h00, ~r[23:0]});
    avs_byteenable <= 4'h2;
    bus(5'h10, 1'b1, 32'hFFFFFFFF);
    avs_byteenable <= 4'hF;
    rd(5'h10, 32'h0000FF00);
    $display("end sync modes");
    bus(5'h08, 1'b1, 32'h00000009);
    bus(5'h0C, 1'b1, 32'h00000000);
    bus(5'h10, 1'b1, 32'h00000004);
    pad_lvl <= 24'h000000;
    repeat (2100) @(posedge core_clk);
    pad_lvl <= 24'h000003;
    @(posedge core_clk);
    pad_lvl <= 24'h000000;
    repeat (40) @(posedge core_clk);
    rd(5'h14, 32'h00000000);
    pad_lvl <= 24'h000003;
    repeat (17) @(posedge core_clk);
    rd(5'h14, 32'h00000001);
    repeat (40) @(posedge core_clk);
    rd(5'h14, 32'h00000003);
    $display("end windows");
    results;
  end
endmodule
bind ppm_port_mux ppm_port_mux_chk #(.EXT_DATA_DFLT(EXT_DATA_DFLT)) ppm_port_mux_chk_i (.core_clk(core_clk),
  .nrst(nrst), .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
  .gpio_out(gpio_out), .gpio_dir(gpio_dir), .gpio_in(gpio_in), .ext_data_out(ext_data_out),
  .ext_data_oe(ext_data_oe), .ext_data_in(ext_data_in), .ext_addr_bit(ext_addr_bit),
  .alt_data_in(alt_data_in), .alt_data_sel(alt_data_sel));
